// ---- design/tplg_gen.sv ----
// Purpose: Line geometry of the test pattern generator: line length and color bar widths.
// Assumes: Register port and frame/line strobes come from logic on clk_in.
//          Line starts are spaced by the frame timing logic, not checked here.
// Notes:   One byte descriptor per cycle leaves through a two-entry buffer.
//          The byte values themselves are formed further down the output path.
//
// Operation
// [R1] Line size is high byte 0x4, low 0x5.
// [R2] Each active line has exactly line-size bytes.
// [R3] Line size resets to 1920 bytes.
// [R4] All bars but last are bar-size bytes wide; the code makes them one byte wide when the bar size is zero.
// [R5] Final bar takes the remaining line bytes.
// [R6] Bar size high byte at 0x6, reset 0x00.
// [R7] Bar size low byte at 0x7, reset 0xf0.
// [R8] Bar count select: 1, 2, 4, 8 bars.
// [R9] Output only while enable bit is set; the code still drains buffered bytes after it clears.
// [R10] Select bit chooses bars or fixed color.
// [R11] Geometry captured at each frame start; the code ignores a frame start during a running line.
`timescale 1ns/1ps
`include "tplg_consts.svh"

module tplg_gen (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  input  wire logic       frame_start_in,
  input  wire logic       line_start_in,
  input  wire logic       beat_ready_in,
  output logic [7:0]      reg_rdata_out,
  output logic            beat_valid_out,
  output logic [2:0]      beat_bar_out,
  output logic            beat_solid_out,
  output logic            beat_first_out,
  output logic            beat_last_out,
  output logic            line_busy_out,
  output logic            generator_on_out
);

  // Whole block state; d is its next value.
  tplg_pkg::tplg_state_s q;
  tplg_pkg::tplg_state_s d;

  logic [15:0]           line_bytes;
  logic [15:0]           bar_bytes;
  logic [2:0]            last_bar;
  logic                  can_push;
  logic                  push;
  logic                  pop;
  tplg_pkg::tplg_beat_s  beat;

  // The bar count setting becomes the index of the final bar, the only bar
  // that may grow past the bar size.
  always_comb begin
    line_bytes = {q.line_high, q.line_low}; // R1
    bar_bytes  = {q.bar_high, q.bar_low};
    case (q.bar_sel_cap) // R8
      2'h0:    last_bar = 3'h0;
      2'h1:    last_bar = 3'h1;
      2'h2:    last_bar = 3'h3;
      2'h3:    last_bar = 3'h7;
      default: last_bar = 3'h7;
    endcase
  end

  always_comb begin
    d = q;

    // Register writes. Offsets outside the map are dropped, so a stray write
    // cannot disturb the geometry.
    if (reg_wr_in) begin
      case (reg_addr_in)
        `TPLG_OFS_CONTROL: begin
          d.gen_on = reg_wdata_in[`TPLG_CTL_ON_BIT];
        end
        `TPLG_OFS_CONFIG: begin
          d.solid_sel  = reg_wdata_in[`TPLG_CFG_SOLID_BIT];
          d.bar_sel    = reg_wdata_in[`TPLG_CFG_BARS_HI:`TPLG_CFG_BARS_LO];
          d.block_size = reg_wdata_in[`TPLG_CFG_BLOCK_HI:`TPLG_CFG_BLOCK_LO];
        end
        `TPLG_OFS_LINE_HIGH: begin
          d.line_high = reg_wdata_in; // R1
        end
        `TPLG_OFS_LINE_LOW: begin
          d.line_low = reg_wdata_in; // R1
        end
        `TPLG_OFS_BAR_HIGH: begin
          d.bar_high = reg_wdata_in; // R6
        end
        `TPLG_OFS_BAR_LOW: begin
          d.bar_low = reg_wdata_in; // R7
        end
        default: begin
        end
      endcase
    end

    // Reads return one cycle later; unmapped and reserved bits read as zero.
    // A read and a write to one offset in the same cycle return the old value.
    if (reg_rd_in) begin
      case (reg_addr_in)
        `TPLG_OFS_CONTROL:   d.rdata = {7'h00, q.gen_on};
        `TPLG_OFS_CONFIG:    d.rdata = {q.solid_sel, 1'h0, q.bar_sel, q.block_size};
        `TPLG_OFS_LINE_HIGH: d.rdata = q.line_high;
        `TPLG_OFS_LINE_LOW:  d.rdata = q.line_low;
        `TPLG_OFS_BAR_HIGH:  d.rdata = q.bar_high;
        `TPLG_OFS_BAR_LOW:   d.rdata = q.bar_low;
        default:             d.rdata = 8'h00;
      endcase
    end

    // Capturing at frame start keeps a line consistent while software
    // rewrites the two halves of a value one byte at a time.
    // A frame start during a running line is ignored, so the line in flight
    // keeps its geometry until it ends.
    if (frame_start_in && !q.active) begin
      d.line_cap    = line_bytes; // R11
      d.bar_cap     = bar_bytes; // R11
      d.bar_sel_cap = q.bar_sel; // R11
      d.solid_cap   = q.solid_sel; // R11
    end

    // A line start while a line is still running is ignored.
    // A zero line size would give a line without a last byte, so it is refused.
    if (line_start_in && !q.active && q.gen_on && q.line_cap != 16'h0000) begin // R9
      d.active   = 1'b1;
      d.byte_cnt = 16'h0000;
      d.bar_pos  = 16'h0000;
      d.bar_idx  = 3'h0;
    end

    // Producer: one byte per cycle while the buffer has room.
    // Push does not look at the sink's ready, which keeps ready off the counter
    // path; the cost is one idle cycle after the skid entry has been used.
    can_push = !q.skid_valid;
    push     = q.active && q.gen_on && can_push; // R9
    beat.bar   = q.solid_cap ? 3'h0 : q.bar_idx; // R10
    beat.solid = q.solid_cap; // R10
    beat.first = (q.byte_cnt == 16'h0000);
    beat.last  = (q.byte_cnt == q.line_cap - 16'h0001); // R2

    if (push) begin
      d.byte_cnt = q.byte_cnt + 16'h0001;
      if (beat.last) begin
        d.active = 1'b0; // R2
      end
      // The final bar never advances, so it absorbs the rest of the line.
      // A bar size of zero is reached on every byte, so it behaves as one.
      // A line shorter than the bars cover simply ends early.
      if (q.bar_idx != last_bar && q.bar_pos + 16'h0001 >= q.bar_cap) begin // R4
        d.bar_idx = q.bar_idx + 3'h1;
        d.bar_pos = 16'h0000;
      end else begin
        d.bar_pos = q.bar_pos + 16'h0001; // R5
      end
    end
    // Clearing the enable stops the line at once; buffered bytes still drain.
    if (!q.gen_on) begin
      d.active = 1'b0; // R9
    end

    // Two-entry buffer: head drives the outputs, skid catches a stalled word.
    // No word is dropped: the skid entry is only filled while the head waits.
    pop = q.head_valid && beat_ready_in;
    if (pop) begin
      if (q.skid_valid) begin
        d.head       = q.skid;
        d.skid_valid = 1'b0;
        if (push) begin
          d.skid       = beat;
          d.skid_valid = 1'b1;
        end
      end else begin
        d.head       = beat;
        d.head_valid = push;
      end
    end else if (push) begin
      if (q.head_valid) begin
        d.skid       = beat;
        d.skid_valid = 1'b1;
      end else begin
        d.head       = beat;
        d.head_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q             <= '0;
      q.gen_on      <= `TPLG_RST_ON; // R9
      q.solid_sel   <= `TPLG_RST_SOLID;
      q.bar_sel     <= `TPLG_RST_BARS; // R8
      q.block_size  <= `TPLG_RST_BLOCK;
      q.line_high   <= `TPLG_RST_LINE_HIGH; // R3
      q.line_low    <= `TPLG_RST_LINE_LOW; // R3
      q.bar_high    <= `TPLG_RST_BAR_HIGH; // R6
      q.bar_low     <= `TPLG_RST_BAR_LOW; // R7
      // Captured geometry resets to the register defaults, so a line may
      // start before the first frame start.
      q.line_cap    <= {`TPLG_RST_LINE_HIGH, `TPLG_RST_LINE_LOW}; // R3
      q.bar_cap     <= {`TPLG_RST_BAR_HIGH, `TPLG_RST_BAR_LOW};
      q.bar_sel_cap <= `TPLG_RST_BARS;
    end else if (ce_in) begin
      q <= d;
    end
  end

  // Every output is a field of the state register.
  assign reg_rdata_out    = q.rdata;
  assign beat_valid_out   = q.head_valid;
  assign beat_bar_out     = q.head.bar;
  assign beat_solid_out   = q.head.solid;
  assign beat_first_out   = q.head.first;
  assign beat_last_out    = q.head.last;
  assign line_busy_out    = q.active;
  assign generator_on_out = q.gen_on;

endmodule

// ---- design/tplg_consts.svh ----
// Purpose: Offsets, field positions, reset values for the test pattern line geometry block.
// Assumes: Byte-wide registers at the offsets below.
// Notes:   Definitions only.
`ifndef TPLG_CONSTS_SVH
`define TPLG_CONSTS_SVH

`define TPLG_ADDR_W            8
`define TPLG_OFS_CONTROL       8'h01
`define TPLG_OFS_CONFIG        8'h02
`define TPLG_OFS_LINE_HIGH     8'h04
`define TPLG_OFS_LINE_LOW      8'h05
`define TPLG_OFS_BAR_HIGH      8'h06
`define TPLG_OFS_BAR_LOW       8'h07

`define TPLG_CTL_ON_BIT        0
`define TPLG_CFG_SOLID_BIT     7
`define TPLG_CFG_BARS_HI       5
`define TPLG_CFG_BARS_LO       4
`define TPLG_CFG_BLOCK_HI      3
`define TPLG_CFG_BLOCK_LO      0

`define TPLG_RST_ON            1'h0
`define TPLG_RST_SOLID         1'h0
`define TPLG_RST_BARS          2'h3
`define TPLG_RST_BLOCK         4'h3
`define TPLG_RST_LINE_HIGH     8'h07
`define TPLG_RST_LINE_LOW      8'h80
`define TPLG_RST_BAR_HIGH      8'h00
`define TPLG_RST_BAR_LOW       8'hf0

`endif

// ---- design/tplg_pkg.sv ----
// Purpose: Types shared by the test pattern line geometry block.
// Assumes: Constants live in tplg_consts.svh.
// Notes:   All module state is one packed struct.
package tplg_pkg;

  typedef struct packed {
    logic [2:0] bar;
    logic       solid;
    logic       first;
    logic       last;
  } tplg_beat_s;

  typedef struct packed {
    logic             gen_on;
    logic             solid_sel;
    logic [1:0]       bar_sel;
    logic [3:0]       block_size;
    logic [7:0]       line_high;
    logic [7:0]       line_low;
    logic [7:0]       bar_high;
    logic [7:0]       bar_low;
    logic [15:0]      line_cap;
    logic [15:0]      bar_cap;
    logic [1:0]       bar_sel_cap;
    logic             solid_cap;
    logic             active;
    logic [15:0]      byte_cnt;
    logic [15:0]      bar_pos;
    logic [2:0]       bar_idx;
    logic [7:0]       rdata;
    tplg_beat_s       head;
    tplg_beat_s       skid;
    logic             head_valid;
    logic             skid_valid;
  } tplg_state_s;

endpackage

// ---- verif/tplg_gen_checker.sv ----
// Purpose: Port-level timing checks for tplg_gen.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Attached by the bind below the module.
`timescale 1ns/1ps
module tplg_gen_checker (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       ce_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_rd_in,
  input wire logic       line_start_in,
  input wire logic       beat_ready_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       beat_valid_out,
  input wire logic [2:0] beat_bar_out,
  input wire logic       beat_solid_out,
  input wire logic       beat_first_out,
  input wire logic       beat_last_out,
  input wire logic       line_busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic rd_go = reg_rd_in && ce_in;
  wire logic push  = beat_valid_out && beat_ready_in && ce_in;
  busy_start_a: assert property ($rose(line_busy_out) |-> $past(line_start_in))
    else $error("line started without a start pulse");
  // A byte of the previous line still waiting in the buffer would delay the first one.
  first_beat_a: assert property ($rose(line_busy_out) && ce_in && !beat_valid_out |=> beat_valid_out
    && beat_first_out && beat_bar_out == 3'h0) else $error("first byte late or not in bar zero");
  // A stalled byte must not change, or the sink would see a lost or altered byte.
  beat_hold_a: assert property (beat_valid_out && !beat_ready_in |=> beat_valid_out
    && $stable({beat_bar_out, beat_first_out, beat_last_out, beat_solid_out})) else $error("stalled byte changed");
  solid_bar_a: assert property (beat_valid_out && beat_solid_out |-> beat_bar_out == 3'h0)
    else $error("fixed color byte carries a bar index");
  rdata_hold_a: assert property (!rd_go |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  unmapped_rd_a: assert property (rd_go && reg_addr_in inside {8'h00, 8'h03, 8'h3f} |=> reg_rdata_out == 8'h00)
    else $error("unmapped offset read nonzero");
  ctrl_rsv_a: assert property (rd_go && reg_addr_in == 8'h01 |=> reg_rdata_out[7:1] == 7'h00)
    else $error("control reserved bits nonzero");
  bar_order_a: assert property (push && !beat_last_out |=> !beat_valid_out || beat_first_out
    || beat_bar_out >= $past(beat_bar_out)) else $error("bar index went backwards");
  cover property (push && beat_last_out);
  cover property (beat_valid_out && !beat_ready_in);
  cover property (beat_valid_out && beat_solid_out);
endmodule
bind tplg_gen tplg_gen_checker u_tplg_gen_checker (.*);

// ---- verif/tplg_sink.sv ----
// Purpose: Byte sink standing behind the generator's stream port.
// Assumes: Ready drops every other cycle while stall_in is high.
// Notes:   Counts bytes per line, per bar and in fixed color for the bench.
`timescale 1ns/1ps
module tplg_sink (
  input  wire logic       clk_in,
  input  wire logic       stall_in,
  input  wire logic       valid_in,
  input  wire logic [2:0] bar_in,
  input  wire logic       solid_in,
  input  wire logic       first_in,
  input  wire logic       last_in,
  output logic            ready_out
);
  int n, len, lines, tick, sol;
  int w [8];
  initial ready_out = 1'b0;
  always @(posedge clk_in) begin
    tick <= tick + 1;
    ready_out <= !stall_in || tick[0];
    if (valid_in && ready_out) begin
      if (first_in) begin
        w = '{default: 0};
        sol = 0;
      end
      n = first_in ? 1 : n + 1;
      sol = sol + solid_in;
      w[bar_in] = w[bar_in] + 1;
      if (last_in) begin
        len = n;
        lines = lines + 1;
      end
    end
  end
endmodule

// ---- verif/tplg_gen_tb.sv ----
// Purpose: Self-checking bench for tplg_gen.
// Assumes: ce_in drops only for one ignored write.
// Notes:   Expected geometry follows only frame starts, never register writes.
`timescale 1ns/1ps
module tplg_gen_tb;
  logic       clk_in, rst_n_in, ce_in, reg_wr_in, reg_rd_in, frame_start_in, line_start_in, beat_ready_in, stall;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [2:0] beat_bar_out;
  logic       beat_valid_out, beat_solid_out, beat_first_out, beat_last_out, line_busy_out, generator_on_out;
  int         n_fail, compares, cur_l, cur_b, cur_n, cur_s;
  tplg_gen u_tplg_gen (.*);
  tplg_sink u_tplg_sink (.clk_in(clk_in), .stall_in(stall), .valid_in(beat_valid_out), .bar_in(beat_bar_out),
    .solid_in(beat_solid_out),
    .first_in(beat_first_out), .last_in(beat_last_out), .ready_out(beat_ready_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_in) reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in) reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_in) reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in) reg_rd_in <= 1'b0;
    @(posedge clk_in) chk("reg_rdata", e, reg_rdata_out);
  endtask
  task automatic t_reset();
    logic [7:0] a [7] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h03};
    logic [7:0] e [7] = '{8'h00, 8'h33, 8'h07, 8'h80, 8'h00, 8'hf0, 8'h00};
    for (int k = 0; k < 7; k++) rd(a[k], e[k]);
    @(posedge clk_in) ce_in <= 1'b0;
    wr(8'h05, 8'h11);
    ce_in <= 1'b1;
    rd(8'h05, 8'h80);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h00);
    wr(8'h06, 8'h5a);
    rd(8'h06, 8'h5a);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h01);
    chk("gen_on", 16'h0001, {15'h0000, generator_on_out});
    $display("t_reset done");
  endtask
  // Writes new geometry; only a frame start makes it the expectation.
  task automatic t_geom(input logic [15:0] l, b, input logic [7:0] cfg, input logic fs, st);
    logic [7:0] v [4] = '{l[15:8], l[7:0], b[15:8], b[7:0]};
    int k, e, rem, nb;
    for (k = 0; k < 4; k++) wr(8'h04 + k[7:0], v[k]);
    wr(8'h02, cfg);
    if (fs) begin
      cur_l = l;
      cur_b = b;
      cur_n = cfg[7] ? 1 : 1 << cfg[5:4];
      cur_s = cfg[7];
    end
    @(posedge clk_in) frame_start_in <= fs;
    stall <= st;
    @(posedge clk_in) frame_start_in <= 1'b0;
    line_start_in <= 1'b1;
    @(posedge clk_in) line_start_in <= 1'b0;
    nb = u_tplg_sink.lines;
    for (k = 0; k < 9000 && u_tplg_sink.lines == nb; k++) @(posedge clk_in);
    chk("line_done", 16'h0001, u_tplg_sink.lines - nb);
    chk("line_bytes", cur_l, u_tplg_sink.len);
    rem = cur_l;
    for (k = 0; k < 8; k++) begin
      e = k >= cur_n ? 0 : (k == cur_n - 1 || rem < cur_b) ? rem : cur_b;
      rem -= e;
      chk("bar_bytes", e, u_tplg_sink.w[k]);
    end
    chk("solid_bytes", cur_s ? cur_l : 0, u_tplg_sink.sol);
    $display("t_geom done");
  endtask
  // A line cut by clearing the enable never delivers its last byte.
  task automatic t_off();
    int nb;
    nb = u_tplg_sink.lines;
    @(posedge clk_in) line_start_in <= 1'b1;
    @(posedge clk_in) line_start_in <= 1'b0;
    wr(8'h01, 8'h00);
    repeat (20) @(posedge clk_in);
    chk("cut_line", 16'h0000, u_tplg_sink.lines - nb);
    chk("gen_on", 16'h0000, {15'h0000, generator_on_out});
    @(posedge clk_in) line_start_in <= 1'b1;
    @(posedge clk_in) line_start_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk("busy_off", 16'h0000, {15'h0000, line_busy_out});
    chk("valid_off", 16'h0000, {15'h0000, beat_valid_out});
    $display("t_off done");
  endtask
  // A reset in mid-run must bring the registers back to their defaults.
  task automatic t_rst();
    wr(8'h04, 8'h12);
    @(posedge clk_in) rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(8'h04, 8'h07);
    rd(8'h07, 8'hf0);
    rd(8'h02, 8'h33);
    $display("t_rst done");
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, frame_start_in, line_start_in, stall} = 6'h00;
    ce_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    cur_l = 1920;
    cur_b = 240;
    cur_n = 8;
    cur_s = 0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_geom(16'h0780, 16'h00f0, 8'h33, 1'h0, 1'h0);
    t_geom(16'h0064, 16'h001e, 8'h23, 1'h1, 1'h1);
    t_geom(16'h00c8, 16'h001e, 8'h10, 1'h0, 1'h0);
    t_geom(16'h000a, 16'h0007, 8'h13, 1'h1, 1'h0);
    t_geom(16'h0014, 16'h0005, 8'h33, 1'h1, 1'h1);
    t_geom(16'h0009, 16'h0004, 8'h03, 1'h1, 1'h0);
    t_geom(16'h000c, 16'h0004, 8'h83, 1'h1, 1'h1);
    t_off();
    t_rst();
    results();
  end
  // Longest run is the default line with margin for the stalled ones.
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    results();
  end
endmodule
